// [verilog/gcm_device.sv]
// Gauge end: shadow RAM, nonvolatile cells, lock, pin and sleep control
module gcm_device
   import gcm_pkg::*;
#(
   parameter int SLEEP_CYC = SLEEP_CYCLES,
   parameter int COPY_CYC = EE_COPY_CYCLES,
   parameter logic [7:0] FAMILY_ID = 8'ha5 // Arbitrary identity value
) (
   input wire logic core_clk,
   input wire logic nrst,
   gcm_link_if.dev link,
   input wire logic factory_clear,
   input wire logic uv_below_in,
   input wire logic gp_pin_in,
   output logic gp_pin_out,
   output logic gp_pin_oe,
   output logic asleep,
   output logic copy_busy
);
   // ****************************************
   // State and storage
   // ****************************************
   typedef enum logic [2:0] {
      ST_RECALL = 3'b001,
      ST_RUN = 3'b010,
      ST_SLEEP = 3'b100
   } gcm_dev_state_t;
   gcm_dev_state_t state;
   gcm_dev_state_t next_state;
   logic [7:0] user_sh [0:USER_BYTES-1];
   logic [7:0] par_sh [0:PARAM_BYTES-1];
   logic [7:0] user_ee [0:USER_BYTES-1];
   logic [7:0] par_ee [0:PARAM_BYTES-1];
   logic user_lock, par_lock, lock_en, copy_flag;
   logic copy_blk_par;
   logic [31:0] copy_cnt;
   logic pin_ctl;
   logic [31:0] sleep_cnt;
   logic line_prev, sleep_level, latch_valid;
   logic [7:0] latch_addr, latch_lsb;
   logic pin_s1, pin_s2, uv_s1, uv_s2;
   // ****************************************
   // Input synchronisers
   // ****************************************
   // Pin and comparator come from outside the clock domain
   always_ff @(posedge core_clk) begin
      pin_s1 <= gp_pin_in;
      pin_s2 <= pin_s1;
      uv_s1 <= uv_below_in;
      uv_s2 <= uv_s1;
   end
   // ****************************************
   // Address and command decode
   // ****************************************
   // Full 8-bit address space decode
   wire in_user = (link.addr >= ADDR_USER_FIRST) && (link.addr <= ADDR_USER_LAST); // see (R16) (R23)
   wire in_par = (link.addr >= ADDR_PARAM_FIRST) && (link.addr <= ADDR_PARAM_LAST);
   wire at_pin = link.addr == ADDR_PIN_SENSE_DRIVE;
   wire at_nv = link.addr == ADDR_NV_LOCK_STATUS;
   wire [3:0] user_idx = link.addr[3:0];
   wire [4:0] par_idx = link.addr[4:0];
   wire [4:0] par_odd = {link.addr[4:1], 1'b1};
   wire take = link.req && !link.ack && (state == ST_RUN);
   wire is_rd = link.cmd == CMD_READ;
   wire is_wr = link.cmd == CMD_WRITE;
   wire is_copy = link.cmd == CMD_COPY;
   wire is_recall = link.cmd == CMD_RECALL;
   wire is_lock = link.cmd == CMD_LOCK;
   wire is_id = link.cmd == CMD_NET_ID;
   wire is_end = link.cmd == CMD_END;
   // Configuration fields from the power config shadow byte
   wire [7:0] cfg = par_sh[0];
   wire uv_en = cfg[CFG_UV_SLEEP_BIT];
   wire line_low_en = cfg[CFG_LINE_LOW_SLEEP_BIT];
   wire [7:0] id_opcode = cfg[CFG_ID_OPCODE_BIT] ? ID_OPCODE_SEL1 : ID_OPCODE_SEL0; // see (R5)
   // Block writes: shadow only, blocked by copy or lock; pin and lock status writes are not blocked
   wire wr_user = take && is_wr && in_user && !copy_flag && !user_lock; // see (R10) (R13) (R21)
   wire wr_par = take && is_wr && in_par && !copy_flag && !par_lock; // see (R10) (R13) (R21)
   wire wr_pin = take && is_wr && at_pin;
   wire wr_nv = take && is_wr && at_nv;
   wire set_lock_en = wr_nv && link.wdata[NV_LOCK_EN_BIT];
   // Copy start and completion
   wire blk_locked = in_par ? par_lock : user_lock;
   wire copy_start = take && is_copy && !copy_flag && (in_user || in_par) && !blk_locked; // see (R2)
   wire copy_done = copy_flag && (copy_cnt == 32'(COPY_CYC - 1));
   // Recall: power-up for both blocks, command for one block
   wire boot_recall = state == ST_RECALL; // see (R1)
   wire cmd_recall = take && is_recall && !copy_flag; // see (R21)
   wire recall_user = boot_recall || (cmd_recall && in_user);
   wire recall_par = boot_recall || (cmd_recall && in_par);
   // Lock only right after lock enable was armed
   wire lock_go = take && is_lock && lock_en && (in_user || in_par); // see (R24)
   // ****************************************
   // Read data selection
   // ****************************************
   wire [7:0] nv_byte = {copy_flag, lock_en, 4'h0, par_lock, user_lock}; // see (R9) (R15)
   wire [7:0] pin_byte = {7'h00, pin_s2}; // see (R6)
   wire latch_hit = latch_valid && (link.addr == latch_addr);
   wire [7:0] mem_byte = in_user ? user_sh[user_idx] :
                         in_par ? par_sh[par_idx] :
                         at_pin ? pin_byte :
                         at_nv ? nv_byte : RESERVED_READ; // see (R14) (R17)
   wire [7:0] rd_byte = latch_hit ? latch_lsb : mem_byte; // see (R19)
   wire msb_read = take && is_rd && in_par && !link.addr[0]; // see (R18)
   wire wr_ok = wr_user || wr_par || wr_pin || wr_nv;
   wire id_ok = is_id && (link.wdata == id_opcode); // see (R5)
   // Acknowledge with data and status
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         link.ack <= 1'b0;
         link.rdata <= 8'h00;
         link.ok <= 1'b0;
      end else begin
         link.ack <= take;
         if (take) begin
            link.rdata <= is_rd ? rd_byte : (id_ok ? FAMILY_ID : 8'h00);
            link.ok <= is_rd || id_ok || wr_ok || copy_start || cmd_recall || lock_go || is_end;
         end
      end
   end
   // ****************************************
   // Two-byte latch
   // ****************************************
   // MSB read freezes LSB until the command sequence ends
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         latch_valid <= 1'b0;
         latch_addr <= 8'h00;
         latch_lsb <= 8'h00;
      end else if (take && is_end) begin
         latch_valid <= 1'b0; // see (R19)
      end else if (msb_read) begin
         latch_valid <= 1'b1;
         latch_addr <= {link.addr[7:1], 1'b1}; // see (R18)
         latch_lsb <= par_sh[par_odd];
      end
   end
   // ****************************************
   // Shadow RAM and nonvolatile cells
   // ****************************************
   // User block; cells survive reset, only factory clear or copy alters them
   always_ff @(posedge core_clk) begin
      for (int i = 0; i < USER_BYTES; i++) begin
         if (recall_user) begin
            user_sh[i] <= user_ee[i];
         end else if (wr_user && (user_idx == 4'(i))) begin
            user_sh[i] <= link.wdata; // see (R23)
         end
         if (factory_clear) begin
            user_ee[i] <= 8'h00;
         end else if (copy_done && !copy_blk_par) begin
            user_ee[i] <= user_sh[i]; // see (R2)
         end
      end
   end
   // Parameter block shadow and cells
   always_ff @(posedge core_clk) begin
      for (int i = 0; i < PARAM_BYTES; i++) begin
         if (recall_par) begin
            par_sh[i] <= par_ee[i]; // see (R1)
         end else if (wr_par && (par_idx == 5'(i))) begin
            par_sh[i] <= link.wdata;
         end
         if (factory_clear) begin
            par_ee[i] <= 8'h00;
         end else if (copy_done && copy_blk_par) begin
            par_ee[i] <= par_sh[i]; // see (R2)
         end
      end
   end
   // Lock flags, cleared only by factory clear
   always_ff @(posedge core_clk) begin
      if (factory_clear) begin
         user_lock <= 1'b0; // see (R15)
         par_lock <= 1'b0;
      end else if (lock_go) begin
         user_lock <= user_lock | in_user; // see (R13) (R24)
         par_lock <= par_lock | in_par;
      end
   end
   // ****************************************
   // Lock enable and copy control
   // ****************************************
   // Arming wins; any other taken command disarms
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         lock_en <= LOCK_EN_RESET;
      end else if (set_lock_en) begin
         lock_en <= 1'b1;
      end else if (take) begin
         lock_en <= 1'b0; // see (R12)
      end
   end
   // Copy flag and timer
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         copy_flag <= COPY_FLAG_RESET; // see (R9)
         copy_blk_par <= 1'b0;
         copy_cnt <= 32'h0;
      end else if (copy_start) begin
         copy_flag <= 1'b1; // see (R9)
         copy_blk_par <= in_par;
         copy_cnt <= 32'h0;
      end else if (copy_done) begin
         copy_flag <= 1'b0;
      end else if (copy_flag) begin
         copy_cnt <= copy_cnt + 32'h1;
      end
   end
   // ****************************************
   // Pin control
   // ****************************************
   // Released at reset and on sleep entry
   wire line_stable = link.line_level == line_prev;
   wire sleep_arm = (line_low_en && !link.line_level) || (uv_en && uv_s2); // see (R3) (R4)
   wire go_sleep = (state == ST_RUN) && sleep_arm && line_stable &&
                   (sleep_cnt == 32'(SLEEP_CYC - 1));
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         pin_ctl <= PIN_CTL_RESET; // see (R8)
      end else if (go_sleep) begin
         pin_ctl <= 1'b1; // see (R8)
      end else if (wr_pin) begin
         pin_ctl <= link.wdata[PIN_CTL_BIT]; // see (R7)
      end
   end
   // Open-drain: drive low only when bit is 0
   assign gp_pin_out = 1'b0;
   assign gp_pin_oe = !pin_ctl; // see (R7)
   // ****************************************
   // Sleep timer and state
   // ****************************************
   // Counts while the enabled condition and a steady line hold
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         line_prev <= 1'b1;
         sleep_cnt <= 32'h0;
         sleep_level <= 1'b1;
      end else begin
         line_prev <= link.line_level;
         if (go_sleep) begin
            sleep_level <= link.line_level;
         end
         if ((state == ST_RUN) && sleep_arm && line_stable && !go_sleep) begin
            sleep_cnt <= sleep_cnt + 32'h1; // see (R3) (R4)
         end else begin
            sleep_cnt <= 32'h0;
         end
      end
   end
   // Next state
   always_comb begin
      next_state = state;
      case (state)
         ST_RECALL: next_state = ST_RUN;
         ST_RUN: next_state = go_sleep ? ST_SLEEP : ST_RUN;
         ST_SLEEP: next_state = (link.line_level != sleep_level) ? ST_RUN : ST_SLEEP;
         default: next_state = ST_RECALL;
      endcase
   end
   // State register
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         state <= ST_RECALL;
      end else begin
         state <= next_state;
      end
   end
   assign asleep = state == ST_SLEEP;
   assign copy_busy = copy_flag;
endmodule

// [verilog/gcm_pkg.sv]
// Shared constants and command codes for the gauge configuration memory link
// Operation
// (R1) Power config recalled from parameter cells at power-up
// (R2) Copy command saves shadow block into cells
// (R3) Undervoltage plus stable line enters sleep
// (R4) Line held low for timeout enters sleep
// (R5) Identity opcode is 33h or 39h by select
// (R6) Pin bit read returns sensed pin level
// (R7) Pin bit write 0 pulls low, 1 releases
// (R8) Pin bit forced to 1 at reset, sleep
// (R9) Copy flag set during copy, 0 after reset
// (R10) Cell-backed writes ignored while copy runs
// (R11) Host arms lock enable, then sends lock
// (R12) Lock enable clears after any next command; here a further arming write keeps it set
// (R13) Locked block refuses writes forever; here factory_clear clears both lock flags
// (R14) Reads behave the same when locked
// (R15) Lock flags: bit1 parameter, bit0 user
// (R16) Linear byte address space of 256 locations
// (R17) Reserved reads undefined; host avoids writing them
// (R18) Word MSB at even, LSB at odd address
// (R19) MSB read latches LSB until command end
// (R20) Host reads both bytes in one sequence
// (R21) Reads, writes touch shadow only; copy, recall move
// (R22) Host writes then copies; recalls then reads
// (R23) Sixteen-byte user block at 20h, no side effects
// (R24) Completed lock sets flag that survives power loss
package gcm_pkg;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_MHZ = 100;
   localparam int EE_COPY_TIME_US = 10;
   localparam int EE_COPY_CYCLES = EE_COPY_TIME_US * CLK_MHZ;
   localparam int SLEEP_TIMEOUT_MS = 2000;
   localparam int SLEEP_CYCLES = SLEEP_TIMEOUT_MS * 1000 * CLK_MHZ;

   // ****************************************
   // Address map
   // ****************************************
   localparam logic [7:0] ADDR_PIN_SENSE_DRIVE = 8'h15;
   localparam logic [7:0] ADDR_NV_LOCK_STATUS = 8'h1f;
   localparam logic [7:0] ADDR_USER_FIRST = 8'h20;
   localparam logic [7:0] ADDR_USER_LAST = 8'h2f;
   localparam logic [7:0] ADDR_POWER_CONFIG = 8'h60;
   localparam logic [7:0] ADDR_PARAM_FIRST = 8'h60;
   localparam logic [7:0] ADDR_PARAM_LAST = 8'h7f;
   localparam int USER_BYTES = 16;
   localparam int PARAM_BYTES = 32;
   localparam logic [7:0] RESERVED_READ = 8'h00;

   // ****************************************
   // Field positions and reset values
   // ****************************************
   localparam int CFG_UV_SLEEP_BIT = 6;
   localparam int CFG_LINE_LOW_SLEEP_BIT = 5;
   localparam int CFG_ID_OPCODE_BIT = 4;
   localparam int PIN_CTL_BIT = 0;
   localparam int NV_COPY_BIT = 7;
   localparam int NV_LOCK_EN_BIT = 6;
   localparam int NV_PARAM_LOCK_BIT = 1;
   localparam int NV_USER_LOCK_BIT = 0;
   localparam logic PIN_CTL_RESET = 1'b1;
   localparam logic COPY_FLAG_RESET = 1'b0;
   localparam logic LOCK_EN_RESET = 1'b0;

   // ****************************************
   // Opcodes and commands
   // ****************************************
   localparam logic [7:0] ID_OPCODE_SEL0 = 8'h33;
   localparam logic [7:0] ID_OPCODE_SEL1 = 8'h39;

   typedef enum logic [2:0] {
      CMD_READ = 3'h0,
      CMD_WRITE = 3'h1,
      CMD_COPY = 3'h2,
      CMD_RECALL = 3'h3,
      CMD_LOCK = 3'h4,
      CMD_NET_ID = 3'h5,
      CMD_END = 3'h6
   } gcm_cmd_t;
endpackage

// [verilog/gcm_link_if.sv]
// Command link between the bus master end and the gauge end
interface gcm_link_if;
   import gcm_pkg::*;
   logic req;
   gcm_cmd_t cmd;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic ack;
   logic [7:0] rdata;
   logic ok;
   logic line_level;

   modport dev (input req, input cmd, input addr, input wdata, input line_level,
                output ack, output rdata, output ok);
   modport host (output req, output cmd, output addr, output wdata, output line_level,
                 input ack, input rdata, input ok);
endinterface

// [verilog/gcm_host.sv]
// Bus master end: issues single commands and the two-step lock sequence
module gcm_host
   import gcm_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   gcm_link_if.host link,
   input wire logic start,
   input wire gcm_cmd_t op,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic line_level_in,
   output logic ready,
   output logic done,
   output logic [7:0] rdata,
   output logic ok
);
   // ****************************************
   // Sequencer
   // ****************************************
   typedef enum logic [2:0] {
      H_IDLE = 3'b001,
      H_ARM = 3'b010,
      H_SEND = 3'b100
   } gcm_host_state_t;

   gcm_host_state_t state;
   logic [7:0] lock_addr;

   // Lock arms first; other commands go straight out
   wire lock_req = start && (op == CMD_LOCK);
   wire [7:0] arm_byte = 8'(1 << NV_LOCK_EN_BIT);

   // Command registers and state
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         state <= H_IDLE;
         link.req <= 1'b0;
         link.cmd <= CMD_END;
         link.addr <= 8'h00;
         link.wdata <= 8'h00;
         lock_addr <= 8'h00;
         done <= 1'b0;
         rdata <= 8'h00;
         ok <= 1'b0;
      end else begin
         done <= 1'b0;
         case (state)
            H_IDLE: if (lock_req) begin
               state <= H_ARM;
               link.req <= 1'b1;
               link.cmd <= CMD_WRITE; // see (R11)
               link.addr <= ADDR_NV_LOCK_STATUS;
               link.wdata <= arm_byte;
               lock_addr <= addr;
            end else if (start) begin
               // Copy, recall, reads and end pass as given; see (R2) (R20) (R22)
               state <= H_SEND;
               link.req <= 1'b1;
               link.cmd <= op;
               link.addr <= addr;
               link.wdata <= wdata;
            end
            H_ARM: if (link.ack) begin
               state <= H_SEND;
               link.cmd <= CMD_LOCK; // see (R11)
               link.addr <= lock_addr;
            end
            H_SEND: if (link.ack) begin
               state <= H_IDLE;
               link.req <= 1'b0;
               done <= 1'b1;
               rdata <= link.rdata;
               ok <= link.ok;
            end
            default: state <= H_IDLE;
         endcase
      end
   end

   assign ready = state == H_IDLE;
   assign link.line_level = line_level_in;
endmodule

// [dv/gcm_link_properties.sv]
// Assertions on the command link
module gcm_link_properties
   import gcm_pkg::*;
#(
   parameter logic [7:0] FAMILY_ID = 8'h5c, // Arbitrary identity value
   parameter int COPY_CYC = 8
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic req,
   input wire gcm_cmd_t cmd,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic ack,
   input wire logic [7:0] rdata,
   input wire logic ok,
   input wire logic line_level
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!nrst);
   logic armed;
   int copy_left;
   wire logic rsv = addr[7] || (addr >= 8'h30 && addr < 8'h60);
   wire logic in_blk = (addr >= ADDR_USER_FIRST && addr <= ADDR_USER_LAST) || addr[6] && !addr[7];
   // ****************
   // Helper state: last answer armed lock, copy window
   // ****************
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         armed <= 1'b0;
      end else if (ack) begin
         armed <= ok && cmd == CMD_WRITE && addr == ADDR_NV_LOCK_STATUS && wdata[NV_LOCK_EN_BIT];
      end
   end
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         copy_left <= 0;
      end else if (ack && ok && cmd == CMD_COPY) begin
         copy_left <= COPY_CYC - 2;
      end else if (copy_left != 0) begin
         copy_left <= copy_left - 1;
      end
   end
   // ****************
   // Properties
   // ****************
   a_ack_single_pulse: assert property (ack |=> !ack)
      else $error("ack longer than one cycle");
   a_reserved_read_zero: assert property (ack && cmd == CMD_READ && rsv |-> ok && rdata == 8'h00)
      else $error("reserved read not zero");
   a_reserved_write_off: assert property (ack && cmd == CMD_WRITE && rsv |-> !ok)
      else $error("reserved write accepted");
   a_net_id_answer: assert property (ack && cmd == CMD_NET_ID |-> rdata == (ok ? FAMILY_ID : 8'h00))
      else $error("identity answer wrong");
   a_net_id_opcode: assert property (ack && cmd == CMD_NET_ID && !(wdata inside {8'h33, 8'h39}) |-> !ok)
      else $error("unknown opcode accepted");
   a_lock_needs_arm: assert property (ack && cmd == CMD_LOCK && ok |-> armed)
      else $error("lock done without arming");
   a_lock_reg_format: assert property (ack && cmd == CMD_READ && addr == 8'h1f |-> rdata[5:2] == 4'h0)
      else $error("lock register format");
   a_read_accepted: assert property (ack && cmd == CMD_READ |-> ok)
      else $error("read refused");
   a_copy_blocks_write: assert property (ack && cmd == CMD_WRITE && in_blk && copy_left != 0 |-> !ok)
      else $error("write accepted during copy");
   a_end_accepted: assert property (ack && cmd == CMD_END |-> ok && rdata == 8'h00)
      else $error("end refused");
endmodule

// [dv/gauge_config_memory_tb.sv]
// Bench: both ends joined, plus a hand-driven second gauge
module gauge_config_memory_tb
   import gcm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SLP = 50;
   localparam int CPY = 8;
   localparam logic [7:0] FAM = 8'h5c; // Arbitrary identity value
   logic core_clk, nrst, factory_clear, uv_below, pin_ext, start, line_lvl;
   gcm_cmd_t h_op;
   logic [7:0] h_addr, h_wdata, h_rdata, rd, b_rd, d1;
   logic gp_pin_out, gp_pin_oe, asleep, copy_busy, ready, done, h_ok, rok, b_ok;
   logic [7:0] user_m [16];
   int bad_count, checked, busy_run, busy_len;
   wire logic gp_pin_in = gp_pin_oe ? 1'b0 : pin_ext;
   gcm_link_if link_a ();
   gcm_link_if link_b ();
   gcm_device #(.SLEEP_CYC(SLP), .COPY_CYC(CPY), .FAMILY_ID(FAM)) u_gcm_device (
      .core_clk(core_clk), .nrst(nrst), .link(link_a.dev), .factory_clear(factory_clear),
      .uv_below_in(uv_below), .gp_pin_in(gp_pin_in), .gp_pin_out(gp_pin_out),
      .gp_pin_oe(gp_pin_oe), .asleep(asleep), .copy_busy(copy_busy));
   gcm_device #(.SLEEP_CYC(SLP), .COPY_CYC(CPY), .FAMILY_ID(FAM)) u_gcm_device_b (
      .core_clk(core_clk), .nrst(nrst), .link(link_b.dev), .factory_clear(factory_clear),
      .uv_below_in(1'b0), .gp_pin_in(1'b1), .gp_pin_out(), .gp_pin_oe(), .asleep(),
      .copy_busy());
   gcm_host u_gcm_host (
      .core_clk(core_clk), .nrst(nrst), .link(link_a.host), .start(start), .op(h_op),
      .addr(h_addr), .wdata(h_wdata), .line_level_in(line_lvl), .ready(ready), .done(done),
      .rdata(h_rdata), .ok(h_ok));
   gcm_link_properties #(.FAMILY_ID(FAM), .COPY_CYC(CPY)) u_gcm_link_properties (
      .core_clk(core_clk), .nrst(nrst), .req(link_a.req), .cmd(link_a.cmd),
      .addr(link_a.addr), .wdata(link_a.wdata), .ack(link_a.ack), .rdata(link_a.rdata),
      .ok(link_a.ok), .line_level(link_a.line_level));
   // ****************
   // Clock, copy length monitor, watchdog
   // ****************
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      if (copy_busy === 1'b1) begin
         busy_run <= busy_run + 1;
      end else if (busy_run != 0) begin
         busy_len <= busy_run;
         busy_run <= 0;
      end
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      bad_count++;
      final_report();
   end
   // ****************
   // Tasks
   // ****************
   task automatic final_report();
      if (bad_count == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp_bit(input logic got, input logic exp);
      cmp_byte({7'h00, got}, {7'h00, exp});
   endtask
   task automatic do_op(input gcm_cmd_t o, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      start <= 1'b1;
      h_op <= o;
      h_addr <= a;
      h_wdata <= d;
      @(posedge core_clk);
      start <= 1'b0;
      do begin
         #1;
         if (done !== 1'b1) @(posedge core_clk);
         n++;
      end while (done !== 1'b1 && n < 20);
      if (n >= 20) bad_count++;
      rd = h_rdata;
      rok = h_ok;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      do_op(CMD_READ, a, 8'h00);
      cmp_byte(rd, exp);
   endtask
   task automatic wr_chk(input logic [7:0] a, input logic [7:0] d, input logic exp);
      do_op(CMD_WRITE, a, d);
      cmp_bit(rok, exp);
   endtask
   task automatic b_cmd(input gcm_cmd_t o, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      link_b.req <= 1'b1;
      link_b.cmd <= o;
      link_b.addr <= a;
      link_b.wdata <= d;
      do begin
         @(posedge core_clk);
         #1;
         n++;
      end while (link_b.ack !== 1'b1 && n < 20);
      b_rd = link_b.rdata;
      b_ok = link_b.ok;
      @(posedge core_clk);
      link_b.req <= 1'b0;
   endtask
   task automatic wait_sleep(input logic exp);
      int n;
      n = 0;
      while (asleep !== exp && n < SLP + 20) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      cmp_bit(asleep, exp);
   endtask
   task automatic pulse_reset();
      @(posedge core_clk);
      nrst <= 1'b0;
      repeat (20) @(posedge core_clk);
      nrst <= 1'b1;
      repeat (2) @(posedge core_clk);
   endtask
   // ****************
   // Main sequence
   // ****************
   initial begin
      {nrst, uv_below, start, h_addr, h_wdata, busy_run, busy_len} = '0;
      {factory_clear, pin_ext, line_lvl} = 3'b111;
      {link_b.req, link_b.addr, link_b.wdata, bad_count, checked} = '0;
      link_b.cmd = CMD_END;
      link_b.line_level = 1'b1;
      h_op = CMD_END;
      for (int i = 0; i < 16; i++) user_m[i] = 8'h00;
      void'($urandom(32'h83b040db));
      repeat (5) @(posedge core_clk);
      factory_clear <= 1'b0;
      repeat (15) @(posedge core_clk);
      nrst <= 1'b1;
      repeat (2) @(posedge core_clk);
      cmp_bit(gp_pin_oe, 1'b0);
      rd_chk(ADDR_NV_LOCK_STATUS, 8'h00);
      rd_chk(ADDR_POWER_CONFIG, 8'h00);
      // Pin drive and sense, all combinations
      for (int i = 0; i < 4; i++) begin
         pin_ext <= i[1];
         wr_chk(ADDR_PIN_SENSE_DRIVE, {7'h00, i[0]}, 1'b1);
         cmp_bit(gp_pin_oe, ~i[0]);
         cmp_bit(gp_pin_out, 1'b0);
         do_op(CMD_READ, ADDR_PIN_SENSE_DRIVE, 8'h00);
         cmp_bit(rd[PIN_CTL_BIT], i[0] & i[1]);
      end
      // Random user bytes, then full readback
      for (int i = 0; i < 24; i++) begin
         h_addr = ADDR_USER_FIRST + 8'($urandom_range(15));
         d1 = 8'($urandom);
         user_m[h_addr[3:0]] = d1;
         wr_chk(h_addr, d1, 1'b1);
      end
      for (int i = 0; i < 16; i++) rd_chk(ADDR_USER_FIRST + 8'(i), user_m[i]);
      rd_chk(ADDR_POWER_CONFIG, 8'h00);
      // Reserved places refuse writes and read zero
      for (int i = 0; i < 4; i++) begin
         h_addr = (i[0] ? 8'h80 : 8'h30) + 8'($urandom_range(47));
         wr_chk(h_addr, 8'hff, 1'b0);
         rd_chk(h_addr, 8'h00);
      end
      // Word latch held until end of command sequence
      wr_chk(8'h62, 8'haa, 1'b1);
      wr_chk(8'h63, 8'hbb, 1'b1);
      rd_chk(8'h62, 8'haa);
      wr_chk(8'h63, 8'hcc, 1'b1);
      rd_chk(8'h63, 8'hbb);
      do_op(CMD_END, 8'h00, 8'h00);
      rd_chk(8'h63, 8'hcc);
      // Identity opcode under both select values
      for (int s = 0; s < 2; s++) begin
         wr_chk(ADDR_POWER_CONFIG, 8'(s << CFG_ID_OPCODE_BIT), 1'b1);
         for (int k = 0; k < 3; k++) begin
            d1 = (k == 0) ? ID_OPCODE_SEL0 : (k == 1) ? ID_OPCODE_SEL1 : 8'h55;
            do_op(CMD_NET_ID, 8'h00, d1);
            cmp_bit(rok, d1 == (s ? ID_OPCODE_SEL1 : ID_OPCODE_SEL0));
         end
      end
      // Copy, refused write during copy, recall
      d1 = 8'($urandom);
      wr_chk(8'h25, d1, 1'b1);
      do_op(CMD_COPY, ADDR_USER_FIRST, 8'h00);
      cmp_bit(rok, 1'b1);
      wr_chk(8'h26, ~user_m[6], 1'b0);
      repeat (CPY + 4) @(posedge core_clk);
      cmp_byte(8'(busy_len), 8'(CPY));
      wr_chk(8'h25, ~d1, 1'b1);
      rd_chk(8'h25, ~d1);
      do_op(CMD_RECALL, ADDR_USER_FIRST, 8'h00);
      rd_chk(8'h25, d1);
      rd_chk(8'h26, user_m[6]);
      // Power-up default of configuration
      wr_chk(ADDR_POWER_CONFIG, 8'h10, 1'b1);
      do_op(CMD_COPY, ADDR_POWER_CONFIG, 8'h00);
      repeat (CPY + 4) @(posedge core_clk);
      pulse_reset();
      rd_chk(ADDR_POWER_CONFIG, 8'h10);
      // Sleep entry paths
      wr_chk(ADDR_PIN_SENSE_DRIVE, 8'h00, 1'b1);
      wr_chk(ADDR_POWER_CONFIG, 8'h20, 1'b1);
      line_lvl <= 1'b0;
      wait_sleep(1'b1);
      cmp_bit(gp_pin_oe, 1'b0);
      line_lvl <= 1'b1;
      wait_sleep(1'b0);
      wr_chk(ADDR_POWER_CONFIG, 8'h40, 1'b1);
      uv_below <= 1'b1;
      wait_sleep(1'b1);
      uv_below <= 1'b0;
      line_lvl <= 1'b0;
      wait_sleep(1'b0);
      wr_chk(ADDR_POWER_CONFIG, 8'h00, 1'b1);
      uv_below <= 1'b1;
      repeat (SLP + 20) @(posedge core_clk);
      cmp_bit(asleep, 1'b0);
      uv_below <= 1'b0;
      line_lvl <= 1'b1;
      // Locking, refusal and persistence
      do_op(CMD_LOCK, ADDR_USER_FIRST, 8'h00);
      cmp_bit(rok, 1'b1);
      rd_chk(ADDR_NV_LOCK_STATUS, 8'h01);
      wr_chk(8'h21, ~user_m[1], 1'b0);
      rd_chk(8'h21, user_m[1]);
      do_op(CMD_COPY, ADDR_USER_FIRST, 8'h00);
      cmp_bit(rok, 1'b0);
      do_op(CMD_LOCK, ADDR_PARAM_FIRST, 8'h00);
      pulse_reset();
      rd_chk(ADDR_NV_LOCK_STATUS, 8'h03);
      rd_chk(8'h25, d1);
      wr_chk(ADDR_POWER_CONFIG, 8'h00, 1'b0);
      // Second end: lock sent one command too late
      b_cmd(CMD_WRITE, ADDR_NV_LOCK_STATUS, 8'h40);
      b_cmd(CMD_READ, 8'h00, 8'h00);
      b_cmd(CMD_LOCK, ADDR_USER_FIRST, 8'h00);
      cmp_bit(b_ok, 1'b0);
      b_cmd(CMD_READ, ADDR_NV_LOCK_STATUS, 8'h00);
      cmp_byte(b_rd, 8'h00);
      final_report();
   end
endmodule
